// [shared/agp_bridge_regs.svh]
// Configuration offsets, field positions, reset values of the bridge window decode.
// Assumes inclusion by bare name from the window decode module.
`ifndef AGP_BRIDGE_REGS_SVH
`define AGP_BRIDGE_REGS_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses in configuration space)
// ----------------------------------------------------------------
`define NP_WIN_BASE_OFF 8'h20
`define NP_WIN_LIMIT_OFF 8'h22
`define PF_WIN_BASE_OFF 8'h24
`define PF_WIN_LIMIT_OFF 8'h26
`define BRIDGE_CTL_OFF 8'h3E
`define SEC_ERR_CMD_OFF 8'h40

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define WIN_FIELD_LSB 4
`define CTL_B2B_BIT 7
`define CTL_SEC_RESET_BIT 6
`define CTL_ABORT_MODE_BIT 5
`define CTL_VGA_BIT 3
`define CTL_ISA_BIT 2
`define CTL_SEC_SERR_BIT 1
`define CTL_PERR_BIT 0
`define ERR_CMD_TA_BIT 0

// ----------------------------------------------------------------
// Reset values and constants
// ----------------------------------------------------------------
`define WIN_FIELD_RST 12'h000
`define CTL_BIT_RST 1'b0
`define ABORT_READ_DATA 32'hFFFFFFFF

`endif

// [shared/agp_bridge_pkg.sv]
// Types shared by the bridge window decode and its helpers.
// Assumes the register header is on the include path.
package agp_bridge_pkg;

  typedef enum logic [1:0] {
    XFER_1X,
    XFER_2X,
    XFER_4X
  } xfer_mode_t;

  typedef struct packed {
    logic valid;
    logic is_io;
    logic [31:0] addr;
  } host_req_t;

  typedef struct packed {
    logic valid;
    logic to_gfx;
    logic prefetch;
  } route_t;

  typedef struct packed {
    logic [11:0] np_base;
    logic [11:0] np_limit;
    logic [11:0] pf_base;
    logic [11:0] pf_limit;
    logic vga_en;
    logic isa_en;
    logic perr_resp;
    logic ta_report;
    logic [31:0] rdata;
    logic rvalid;
    route_t route;
    logic syserr;
    logic cpl_valid;
    logic [31:0] cpl_data;
    logic wdrop;
    logic b2b;
    logic sec_reset;
  } state_t;

endpackage

// [verilog/window_match.sv]
// Inclusive 1 MB window compare on address bits 31 to 20.
// Assumes base and limit fields come straight from configuration registers.
`timescale 1ns/1ps
module window_match #(
  parameter int FIELD_W = 12
) (
  input wire logic [FIELD_W-1:0] base_i,
  input wire logic [FIELD_W-1:0] limit_i,
  input wire logic [FIELD_W-1:0] addr_hi_i,
  output logic hit_o
);

  // Comparing only the upper field means the low twenty bits act as zeros
  // against the base and as ones against the limit, so the window always
  // spans whole megabytes.
  always_comb begin
    hit_o = (addr_hi_i >= base_i) && (addr_hi_i <= limit_i);
  end

endmodule

// [verilog/legacy_io_decode.sv]
// Legacy video and monochrome I/O address classification.
// Assumes a 16-bit host I/O address; only bits 9:0 are examined.
`timescale 1ns/1ps
module legacy_io_decode (
  input wire logic [15:0] io_addr_i,
  output logic vga_io_o,
  output logic printer_alias_o,
  output logic mono_io_o
);

  logic [9:0] a;

  // Bits 15:10 are left out so every 1 KB alias matches.
  always_comb begin
    a = io_addr_i[9:0];
    vga_io_o = ((a >= 10'h3B0) && (a <= 10'h3BB)) || ((a >= 10'h3C0) && (a <= 10'h3DF));
    printer_alias_o = (a >= 10'h3BC) && (a <= 10'h3BF);
    mono_io_o = (a == 10'h3B4) || (a == 10'h3B5) || (a == 10'h3B8) ||
                (a == 10'h3B9) || (a == 10'h3BA) || (a == 10'h3BF);
  end

endmodule

// [verilog/agp_bridge_window_decode.sv]
// Window decode and secondary-side control of the virtual bridge to the graphics port.
// Assumes host requests, graphics port events and configuration cycles come from
// logic on clock_i, so none of them is synchronised here.
// Assumes software keeps monochrome decode off while video enable is clear.
//
// How it works
// - Memory address bits 31:20 within non-prefetchable base..limit go to graphics port.
// - Window base low twenty bits count as zero; windows start on 1 MB.
// - Window limit low twenty bits count as ones; windows end 1 MB top.
// - Window registers keep bits 15:4; bits 3:0 read zero, ignore writes.
// - Memory within prefetchable base..limit also goes to graphics port.
// - Back-to-back enable reads zero; back-to-back only in 2x/4x fast write.
// - Secondary reset bit reads zero and never resets the graphics port.
// - Abort mode reads zero; master-aborted writes dropped, reads return ones.
// - Video enable sends 0A0000h-0BFFFFh memory to graphics port.
// - Video enable sends I/O 3B0-3BB, 3C0-3DF, all aliases, to graphics port.
// - Video forwarding ignores windows and the ISA enable bit.
// - Video enable clear: legacy video goes to hub unless a window claims it.
// - Video set, mono decode clear: 3BF to hub; both set: mono to hub.
// - Video clear: printer alias I/O routed like ordinary I/O.
// - ISA enable keeps upper 768 bytes of each 1 KB off graphics port.
// - ISA enable clear: whole I/O window goes to graphics port.
// - Secondary system-error forwarding bit reads zero.
// - Parity response set: port parity errors raise system error if both enabled.
// - Parity response clear: parity errors silent, other errors still reported.
// - Target-abort enable sends system-error message on own cycle's target abort.
// - I/O window bits 15:12 come from the I/O base and limit registers.
// - Mono adapter present: mono memory and mono I/O go to the hub.
`timescale 1ns/1ps
`include "agp_bridge_regs.svh"
module agp_bridge_window_decode (
  input wire logic clock_i,
  input wire logic rst_n_i,
  // Configuration cycles, one dword per access with byte enables.
  input wire logic cfg_wr_i,
  input wire logic cfg_rd_i,
  input wire logic [7:0] cfg_addr_i,
  input wire logic [3:0] cfg_be_i,
  input wire logic [31:0] cfg_wdata_i,
  output logic [31:0] cfg_rdata_o,
  output logic cfg_rvalid_o,

  // Bits held in neighbouring configuration registers.
  input wire logic [3:0] io_window_low_i,
  input wire logic [3:0] io_window_high_i,
  input wire logic secondary_syserr_enable_i,
  input wire logic primary_syserr_enable_i,
  input wire logic mono_adapter_present_i,

  // Host request to be steered.
  input wire agp_bridge_pkg::host_req_t host_req_i,
  output agp_bridge_pkg::route_t route_o,

  // Graphics port cycle outcomes for cycles this bridge started.
  input wire logic gfx_addr_parity_err_i,
  input wire logic gfx_data_parity_err_i,
  input wire logic gfx_target_abort_i,
  input wire logic gfx_master_abort_i,
  input wire logic gfx_cycle_is_read_i,
  input wire logic fast_write_i,
  input wire agp_bridge_pkg::xfer_mode_t xfer_mode_i,
  output logic syserr_msg_o,
  output logic abort_cpl_valid_o,
  output logic [31:0] abort_cpl_data_o,
  output logic abort_write_drop_o,
  output logic back_to_back_cycles_o,
  output logic gfx_reset_o
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  agp_bridge_pkg::state_t st_r;
  agp_bridge_pkg::state_t st_nxt;

  // Classification of the current host request.
  logic np_hit;
  logic pf_hit;
  logic vga_io;
  logic printer_alias;
  logic mono_io;

  // ----------------------------------------------------------------
  // Window and legacy classification
  // ----------------------------------------------------------------
  // Entry 0 is the non-prefetchable window and entry 1 the prefetchable one.
  logic [1:0][11:0] win_base;
  logic [1:0][11:0] win_limit;
  logic [1:0] win_hit;

  assign win_base = {st_r.pf_base, st_r.np_base};
  assign win_limit = {st_r.pf_limit, st_r.np_limit};

  for (genvar w = 0; w < 2; w++) begin : g_window
    window_match #(
      .FIELD_W(12)
    ) u_match (
      .base_i(win_base[w]),
      .limit_i(win_limit[w]),
      .addr_hi_i(host_req_i.addr[31:20]),
      .hit_o(win_hit[w])
    );
  end

  assign np_hit = win_hit[0];
  assign pf_hit = win_hit[1];

  // Only bits 9:0 matter there, so each 1 KB alias lands in the same class.
  legacy_io_decode u_legacy_io (
    .io_addr_i(host_req_i.addr[15:0]),
    .vga_io_o(vga_io),
    .printer_alias_o(printer_alias),
    .mono_io_o(mono_io)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Merges a halfword write into a 12-bit window field held in bits 15:4.
  // Bits 3:0 of the halfword have no storage, so writes to them vanish.
  function automatic logic [11:0] merge_field(
    input logic [11:0] cur,
    input logic [15:0] wd,
    input logic [1:0] be
  );
    logic [11:0] res;
    res = cur;
    if (be[0]) begin
      res[3:0] = wd[7:4];
    end
    if (be[1]) begin
      res[11:4] = wd[15:8];
    end
    return res;
  endfunction

  function automatic logic dword_hit(
    input logic [7:0] a,
    input logic [7:0] off
  );
    // Byte lanes are picked by the enables, so only bits 7:2 pick the dword.
    return a[7:2] == off[7:2];
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic [15:0] io_addr;
  logic io_in_window;
  logic isa_block;
  logic vga_mem;
  logic mono_mem;
  logic mem_gfx;
  logic io_gfx;
  logic parity_err;
  logic parity_report;
  logic abort_report;

  always_comb begin
    st_nxt = st_r;
    // Every field holds unless a branch below changes it.

    // Configuration writes.
    if (cfg_wr_i) begin
      if (dword_hit(cfg_addr_i, `NP_WIN_BASE_OFF)) begin
        st_nxt.np_base = merge_field(st_r.np_base, cfg_wdata_i[15:0], cfg_be_i[1:0]);
        st_nxt.np_limit = merge_field(st_r.np_limit, cfg_wdata_i[31:16], cfg_be_i[3:2]);
      end
      if (dword_hit(cfg_addr_i, `PF_WIN_BASE_OFF)) begin
        st_nxt.pf_base = merge_field(st_r.pf_base, cfg_wdata_i[15:0], cfg_be_i[1:0]);
        st_nxt.pf_limit = merge_field(st_r.pf_limit, cfg_wdata_i[31:16], cfg_be_i[3:2]);
      end
      // Control sits in lane 2 of its dword. Bits 7, 6, 5 and 1 have no
      // storage, so a write there changes nothing.
      if (dword_hit(cfg_addr_i, `BRIDGE_CTL_OFF) && cfg_be_i[2]) begin
        st_nxt.vga_en = cfg_wdata_i[16 + `CTL_VGA_BIT];
        st_nxt.isa_en = cfg_wdata_i[16 + `CTL_ISA_BIT];
        st_nxt.perr_resp = cfg_wdata_i[16 + `CTL_PERR_BIT];
      end
      if (dword_hit(cfg_addr_i, `SEC_ERR_CMD_OFF) && cfg_be_i[0]) begin
        st_nxt.ta_report = cfg_wdata_i[`ERR_CMD_TA_BIT];
      end
    end

    // Configuration reads answer one cycle later; unmapped dwords read zero.
    // A read beside a write to the same dword returns the contents before the write.
    st_nxt.rvalid = cfg_rd_i;
    st_nxt.rdata = 32'h00000000;
    if (cfg_rd_i) begin
      if (dword_hit(cfg_addr_i, `NP_WIN_BASE_OFF)) begin
        st_nxt.rdata = {st_r.np_limit, 4'h0, st_r.np_base, 4'h0};
      end else if (dword_hit(cfg_addr_i, `PF_WIN_BASE_OFF)) begin
        st_nxt.rdata = {st_r.pf_limit, 4'h0, st_r.pf_base, 4'h0};
      end else if (dword_hit(cfg_addr_i, `BRIDGE_CTL_OFF)) begin
        st_nxt.rdata[16 + `CTL_VGA_BIT] = st_r.vga_en;
        st_nxt.rdata[16 + `CTL_ISA_BIT] = st_r.isa_en;
        st_nxt.rdata[16 + `CTL_PERR_BIT] = st_r.perr_resp;
      end else if (dword_hit(cfg_addr_i, `SEC_ERR_CMD_OFF)) begin
        st_nxt.rdata[`ERR_CMD_TA_BIT] = st_r.ta_report;
      end
    end

    // Unclaimed accesses fall through to the hub.
    st_nxt.route.valid = host_req_i.valid;
    st_nxt.route.to_gfx = host_req_i.valid && (host_req_i.is_io ? io_gfx : mem_gfx);
    st_nxt.route.prefetch = host_req_i.valid && !host_req_i.is_io && pf_hit && !np_hit &&
                            st_nxt.route.to_gfx;

    // System-error message. Parity needs three enables; target abort only its own.
    // Several events in one cycle still give a single message.
    parity_err = gfx_addr_parity_err_i || gfx_data_parity_err_i;
    parity_report = parity_err && st_r.perr_resp &&
                    secondary_syserr_enable_i && primary_syserr_enable_i;
    abort_report = gfx_target_abort_i && st_r.ta_report;
    st_nxt.syserr = parity_report || abort_report;

    // Master abort: reads complete with all ones, write data is thrown away.
    st_nxt.cpl_valid = gfx_master_abort_i && gfx_cycle_is_read_i;
    // Data stays zero outside a completion so a stray sample never looks like ones.
    st_nxt.cpl_data = st_nxt.cpl_valid ? `ABORT_READ_DATA : 32'h00000000;
    st_nxt.wdrop = gfx_master_abort_i && !gfx_cycle_is_read_i;

    // Back-to-back only in fast write at 2x or 4x, never in 1x.
    st_nxt.b2b = fast_write_i && (xfer_mode_i != agp_bridge_pkg::XFER_1X);

    // The port is only reset by system reset, never from configuration.
    st_nxt.sec_reset = 1'b0;
  end

  // ----------------------------------------------------------------
  // Routing decode
  // ----------------------------------------------------------------
  // The decode looks at the window registers as they stood before the request's
  // edge, so a configuration write in the same cycle only steers later requests.
  always_comb begin
    io_addr = host_req_i.addr[15:0];

    // Memory routing.
    vga_mem = (host_req_i.addr >= 32'h000A0000) && (host_req_i.addr <= 32'h000BFFFF);
    mono_mem = (host_req_i.addr >= 32'h000B0000) && (host_req_i.addr <= 32'h000B7FFF);
    mem_gfx = np_hit || pf_hit;
    if (st_r.vga_en && vga_mem) begin
      mem_gfx = 1'b1;
    end
    // The monochrome card lives behind the hub; its range wins over video.
    if (mono_adapter_present_i && mono_mem) begin
      mem_gfx = 1'b0;
    end

    // I/O routing.
    // The I/O window spans whole 4 KB blocks, so bits 11:0 take no part.
    io_in_window = (io_addr[15:12] >= io_window_low_i) &&
                   (io_addr[15:12] <= io_window_high_i);
    isa_block = st_r.isa_en && (io_addr[9:8] != 2'b00);
    io_gfx = io_in_window && !isa_block;
    if (st_r.vga_en) begin
      if (vga_io) begin
        io_gfx = 1'b1;
      end else if (printer_alias) begin
        io_gfx = 1'b0;
      end
    end
    if (mono_adapter_present_i && mono_io) begin
      io_gfx = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r <= '0;
      st_r.np_base <= `WIN_FIELD_RST;
      st_r.np_limit <= `WIN_FIELD_RST;
      st_r.pf_base <= `WIN_FIELD_RST;
      st_r.pf_limit <= `WIN_FIELD_RST;
      st_r.vga_en <= `CTL_BIT_RST;
      st_r.isa_en <= `CTL_BIT_RST;
      st_r.perr_resp <= `CTL_BIT_RST;
      st_r.ta_report <= `CTL_BIT_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Every output is a bit of st_r, so no decode glitch reaches a pin.
  assign cfg_rdata_o = st_r.rdata;
  assign cfg_rvalid_o = st_r.rvalid;
  assign route_o = st_r.route;
  assign syserr_msg_o = st_r.syserr;
  assign abort_cpl_valid_o = st_r.cpl_valid;
  assign abort_cpl_data_o = st_r.cpl_data;
  assign abort_write_drop_o = st_r.wdrop;
  assign back_to_back_cycles_o = st_r.b2b;
  assign gfx_reset_o = st_r.sec_reset;

endmodule

// [verif/agp_bridge_window_decode_checker.sv]
// Port assertions for the bridge window decode.
// Assumes one clock domain and the bind at the foot of this file.
`timescale 1ns/1ps
module agp_bridge_window_decode_checker (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic cfg_rd_i,
  input wire logic [7:0] cfg_addr_i,
  input wire logic [31:0] cfg_rdata_o,
  input wire logic cfg_rvalid_o,
  input wire logic secondary_syserr_enable_i,
  input wire logic primary_syserr_enable_i,
  input wire agp_bridge_pkg::host_req_t host_req_i,
  input wire agp_bridge_pkg::route_t route_o,
  input wire logic gfx_addr_parity_err_i,
  input wire logic gfx_data_parity_err_i,
  input wire logic gfx_target_abort_i,
  input wire logic gfx_master_abort_i,
  input wire logic gfx_cycle_is_read_i,
  input wire logic fast_write_i,
  input wire agp_bridge_pkg::xfer_mode_t xfer_mode_i,
  input wire logic syserr_msg_o,
  input wire logic abort_cpl_valid_o,
  input wire logic [31:0] abort_cpl_data_o,
  input wire logic abort_write_drop_o,
  input wire logic back_to_back_cycles_o,
  input wire logic gfx_reset_o
);
  logic b2b_cause;
  logic err_any;
  assign b2b_cause = fast_write_i && (xfer_mode_i != agp_bridge_pkg::XFER_1X);
  assign err_any = gfx_addr_parity_err_i || gfx_data_parity_err_i || gfx_target_abort_i;
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_n_i);
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_read_answer: assert property (cfg_rd_i |=> cfg_rvalid_o)
    else $error("read got no answer");
  a_window_low_zero: assert property (
    cfg_rvalid_o && $past(cfg_addr_i[7:3]) == 5'h04 |->
    cfg_rdata_o[3:0] == 4'h0 && cfg_rdata_o[19:16] == 4'h0)
    else $error("window low bits not zero");
  a_ctl_fixed_zero: assert property (
    cfg_rvalid_o && $past(cfg_addr_i[7:2]) == 6'h0F |->
    cfg_rdata_o[23:20] == 4'h0 && !cfg_rdata_o[17])
    else $error("fixed control bits not zero");
  a_route_one_cycle: assert property (
    1'b1 |=> route_o.valid == $past(host_req_i.valid))
    else $error("route answer not one cycle after request");
  a_abort_read_ones: assert property (
    gfx_master_abort_i && gfx_cycle_is_read_i |=>
    abort_cpl_valid_o && abort_cpl_data_o == 32'hFFFFFFFF)
    else $error("aborted read did not return ones");
  a_abort_write_drop: assert property (
    gfx_master_abort_i && !gfx_cycle_is_read_i |=> abort_write_drop_o && !abort_cpl_valid_o)
    else $error("aborted write not dropped");
  a_no_gfx_reset: assert property (!gfx_reset_o)
    else $error("graphics port reset driven");
  a_b2b_mode: assert property (1'b1 |=> back_to_back_cycles_o == $past(b2b_cause))
    else $error("back to back output wrong for mode");
  a_syserr_cause: assert property (syserr_msg_o |-> $past(err_any))
    else $error("system error without cause");
  a_parity_gated: assert property (
    (!secondary_syserr_enable_i || !primary_syserr_enable_i) && !gfx_target_abort_i
    |=> !syserr_msg_o)
    else $error("parity reported while disabled");
  c_read: cover property (cfg_rvalid_o);
  c_syserr: cover property (syserr_msg_o);
  c_prefetch: cover property (route_o.valid && route_o.to_gfx && route_o.prefetch);
endmodule

bind agp_bridge_window_decode agp_bridge_window_decode_checker u_chk (
  .clock_i, .rst_n_i, .cfg_rd_i, .cfg_addr_i, .cfg_rdata_o, .cfg_rvalid_o,
  .secondary_syserr_enable_i, .primary_syserr_enable_i, .host_req_i, .route_o,
  .gfx_addr_parity_err_i, .gfx_data_parity_err_i, .gfx_target_abort_i,
  .gfx_master_abort_i, .gfx_cycle_is_read_i, .fast_write_i, .xfer_mode_i,
  .syserr_msg_o, .abort_cpl_valid_o, .abort_cpl_data_o, .abort_write_drop_o,
  .back_to_back_cycles_o, .gfx_reset_o);

// [verif/gfx_port_model.sv]
// Graphics port device model: outcome pulses of cycles the bridge started.
// Assumes one requested outcome per go pulse, sampled on clock_i.
`timescale 1ns/1ps
module gfx_port_model (
  input wire logic clock_i,
  input wire logic go_i,
  input wire logic [2:0] kind_i,
  output logic addr_par_o,
  output logic data_par_o,
  output logic tabort_o,
  output logic mabort_o,
  output logic is_read_o
);
  logic g;
  logic [2:0] k;
  initial begin
    {addr_par_o, data_par_o, tabort_o, mabort_o, is_read_o} = 5'h00;
  end
  always @(posedge clock_i) begin
    g = go_i;
    k = kind_i;
    #1;
    addr_par_o = g && k == 3'h0;
    data_par_o = g && k == 3'h1;
    tabort_o = g && k == 3'h2;
    mabort_o = g && k[2];
    // The read qualifier means nothing outside an abort, so it wanders then.
    is_read_o = (g && k[2]) ? (k == 3'h4) : !is_read_o;
  end
endmodule

// [verif/agp_bridge_window_decode_tb_top.sv]
// Self-checking bench for the bridge window decode.
// Assumes the checker binds itself and the port model supplies outcomes.
`timescale 1ns/1ps
module agp_bridge_window_decode_tb_top;
  logic clock_i = 0;
  logic rst_n_i = 0;
  logic cfg_wr_i = 0;
  logic cfg_rd_i = 0;
  logic [7:0] cfg_addr_i = 0;
  logic [3:0] cfg_be_i = 0;
  logic [31:0] cfg_wdata_i = 0;
  logic [31:0] cfg_rdata_o;
  logic [31:0] acd;
  logic cfg_rvalid_o, ap, dp, ta, ma, rd, se, acv, awd, b2b, grst;
  logic [3:0] io_lo = 0;
  logic [3:0] io_hi = 0;
  logic sec_se = 0;
  logic pri_se = 0;
  logic mono = 0;
  logic go = 0;
  logic fw = 0;
  logic [2:0] kind = 0;
  agp_bridge_pkg::xfer_mode_t mode = agp_bridge_pkg::XFER_1X;
  agp_bridge_pkg::host_req_t req = '0;
  agp_bridge_pkg::route_t route_o;
  int miscompares = 0;
  int checks_done = 0;
  always #25 clock_i = ~clock_i;
  gfx_port_model u_gfx (.clock_i(clock_i), .go_i(go), .kind_i(kind), .addr_par_o(ap),
    .data_par_o(dp), .tabort_o(ta), .mabort_o(ma), .is_read_o(rd));
  agp_bridge_window_decode DUT (.clock_i(clock_i), .rst_n_i(rst_n_i), .cfg_wr_i(cfg_wr_i),
    .cfg_rd_i(cfg_rd_i), .cfg_addr_i(cfg_addr_i), .cfg_be_i(cfg_be_i),
    .cfg_wdata_i(cfg_wdata_i), .cfg_rdata_o(cfg_rdata_o), .cfg_rvalid_o(cfg_rvalid_o),
    .io_window_low_i(io_lo), .io_window_high_i(io_hi), .secondary_syserr_enable_i(sec_se),
    .primary_syserr_enable_i(pri_se), .mono_adapter_present_i(mono), .host_req_i(req),
    .route_o(route_o), .gfx_addr_parity_err_i(ap), .gfx_data_parity_err_i(dp),
    .gfx_target_abort_i(ta), .gfx_master_abort_i(ma), .gfx_cycle_is_read_i(rd),
    .fast_write_i(fw), .xfer_mode_i(mode), .syserr_msg_o(se), .abort_cpl_valid_o(acv),
    .abort_cpl_data_o(acd), .abort_write_drop_o(awd), .back_to_back_cycles_o(b2b),
    .gfx_reset_o(grst));
  // ----------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      $display("BAD %0t got %h expected %h", $time, got, exp);
      miscompares++;
    end
  endtask
  task automatic cw(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    @(posedge clock_i) #1;
    {cfg_wr_i, cfg_addr_i, cfg_be_i, cfg_wdata_i} = {1'b1, a, be, d};
    @(posedge clock_i) #1;
    {cfg_wr_i, cfg_wdata_i} = {1'b0, ~d};
  endtask
  task automatic cr(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clock_i) #1;
    {cfg_rd_i, cfg_addr_i} = {1'b1, a};
    @(posedge clock_i) #1;
    {cfg_rd_i, cfg_addr_i} = {1'b0, ~a};
    cmp({31'h0, cfg_rvalid_o}, 32'h1);
    cmp(cfg_rdata_o, exp);
  endtask
  task automatic rt(input logic io, input logic [31:0] a, input logic g, input logic p);
    @(posedge clock_i) #1;
    req = {1'b1, io, a};
    @(posedge clock_i) #1;
    req = {1'b0, ~io, ~a};
    cmp({29'h0, route_o}, {29'h0, 1'b1, g, p});
  endtask
  // The model answers one cycle after go; the bridge one cycle after that.
  task automatic ev(input logic [2:0] k, input logic [4:0] exp);
    @(posedge clock_i) #1;
    {go, kind} = {1'b1, k};
    @(posedge clock_i) #1;
    go = 0;
    @(posedge clock_i) #1;
    cmp({27'h0, se, acv, awd, acd[0], acd[31]}, {27'h0, exp});
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clock_i);
    miscompares++;
    end_sim();
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clock_i);
    #1 rst_n_i = 1;
    cr(8'h20, 32'h0);
    cr(8'h3C, 32'h0);
    cr(8'h40, 32'h0);
    cw(8'h20, 4'hF, 32'hFFFFFFFF);
    cr(8'h20, 32'hFFF0FFF0);
    cw(8'h24, 4'h1, 32'hFFFFFFFF);
    cr(8'h24, 32'h000000F0);
    cw(8'h3C, 4'h4, 32'hFFFFFFFF);
    cr(8'h3C, 32'h000D0000);
    cw(8'h40, 4'hF, 32'hFFFFFFFF);
    cr(8'h40, 32'h1);
    cw(8'h44, 4'hF, 32'hFFFFFFFF);
    cr(8'h44, 32'h0);
    cw(8'h20, 4'hF, 32'h1FF01000);
    cw(8'h24, 4'hF, 32'h30003000);
    cw(8'h3C, 4'h4, 32'h0);
    rt(0, 32'h0FFFFFFF, 0, 0);
    rt(0, 32'h10000000, 1, 0);
    rt(0, 32'h1FFFFFFF, 1, 0);
    rt(0, 32'h20000000, 0, 0);
    rt(0, 32'h300ABCDE, 1, 1);
    rt(0, 32'h30100000, 0, 0);
    rt(0, 32'h000A0000, 0, 0);
    {io_lo, io_hi} = 8'h11;
    rt(1, 32'h00001300, 1, 0);
    rt(1, 32'h000013BC, 1, 0);
    rt(1, 32'h000003C0, 0, 0);
    rt(1, 32'h00002000, 0, 0);
    cw(8'h3C, 4'h4, 32'h00040000);
    rt(1, 32'h00001300, 0, 0);
    rt(1, 32'h000010FF, 1, 0);
    rt(1, 32'h000013BC, 0, 0);
    cw(8'h3C, 4'h4, 32'h000C0000);
    rt(0, 32'h000A0000, 1, 0);
    rt(0, 32'h000BFFFF, 1, 0);
    rt(0, 32'h000C0000, 0, 0);
    rt(1, 32'h0000FBB0, 1, 0);
    rt(1, 32'h000003BB, 1, 0);
    rt(1, 32'h000013C0, 1, 0);
    rt(1, 32'h000003BF, 0, 0);
    mono = 1;
    rt(1, 32'h000003B4, 0, 0);
    rt(0, 32'h000B7FFF, 0, 0);
    rt(0, 32'h000B8000, 1, 0);
    mono = 0;
    cw(8'h3C, 4'h4, 32'h0);
    cw(8'h20, 4'hF, 32'h0);
    rt(0, 32'h000A0000, 1, 0);
    fw = 1'b1;
    mode = agp_bridge_pkg::XFER_2X;
    ev(3'h4, 5'b01011);
    ev(3'h5, 5'b00100);
    cmp({31'h0, b2b}, 32'h1);
    {sec_se, pri_se} = 2'b11;
    ev(3'h0, 5'b00000);
    ev(3'h2, 5'b10000);
    cw(8'h40, 4'h1, 32'h0);
    ev(3'h2, 5'b00000);
    cw(8'h3C, 4'h4, 32'h00010000);
    ev(3'h1, 5'b10000);
    ev(3'h0, 5'b10000);
    pri_se = 0;
    ev(3'h1, 5'b00000);
    mode = agp_bridge_pkg::XFER_4X;
    @(posedge clock_i) #1;
    cmp({31'h0, b2b}, 32'h1);
    fw = 0;
    @(posedge clock_i) #1;
    cmp({31'h0, b2b}, 32'h0);
    fw = 1;
    mode = agp_bridge_pkg::XFER_1X;
    @(posedge clock_i) #1;
    cmp({31'h0, b2b}, 32'h0);
    cmp({31'h0, grst}, 32'h0);
    end_sim();
  end
endmodule
